// *** hw/tdc_trip_counter.sv ***
// tdc_trip_counter: direction change trip counter with limit and blocking
// assumes nv_image is valid while nv_ready is high, nv writes always taken
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module tdc_trip_counter #(
  parameter logic [63:0] DAY_CYCLES = tdc_pkg::DAY_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic trip_req,
  input wire logic trip_dir,
  input wire logic trip_done,
  output logic trip_accept,
  output logic trip_reject,
  output logic fault,
  output tdc_pkg::tdc_display_t display,
  input wire logic nv_ready,
  input wire tdc_pkg::tdc_nv_image_t nv_image,
  output tdc_pkg::tdc_nv_wr_t nv_wr
);

  if (DAY_CYCLES < 64'h2) begin : g_bad_day
    $error("DAY_CYCLES must be at least 2");
  end

  // counters travel as whole bus and nv words, so no padding logic exists
  if (tdc_pkg::CNT_W != 32) begin : g_bad_cnt
    $error("CNT_W must equal the 32 bit word width");
  end

  // status and mask reads pad the interrupt bits to a full word
  if (tdc_pkg::IRQ_W != 4) begin : g_bad_irq
    $error("IRQ_W must be 4 to fit the read word");
  end

  // log count is stored and read back as the low half of a word
  if (tdc_pkg::LOG_W != 16) begin : g_bad_log
    $error("LOG_W must be 16 to fit the nv word");
  end

  // log entry must drain last, after the words it refers to
  if (tdc_pkg::SLOT_LOG != tdc_pkg::SLOT_N - 1) begin : g_bad_slot
    $error("SLOT_LOG must be the last nv slot");
  end

  tdc_pkg::tdc_state_t state, next_state;
  tdc_pkg::tdc_nv_image_t img, next_img;
  logic unlocked, next_unlocked;
  logic extra, next_extra;
  logic warn, next_warn;
  logic [tdc_pkg::IRQ_W-1:0] irq_status, next_irq_status;
  logic [tdc_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [63:0] day_cnt, next_day_cnt;
  logic [15:0] day_trips, next_day_trips;
  logic [31:0] avg, next_avg;
  logic [tdc_pkg::SLOT_N-1:0] pend, next_pend;
  logic [31:0] log_word, next_log_word;
  logic [7:0] log_addr, next_log_addr;
  logic [31:0] next_rdata;
  logic next_irq, next_accept, next_reject, next_fault;
  tdc_pkg::tdc_display_t next_display;
  tdc_pkg::tdc_nv_wr_t next_nv_wr;

  logic blocked, next_blocked;
  logic [tdc_pkg::IRQ_W-1:0] ev;
  logic [tdc_pkg::SLOT_N-1:0] new_pend, served;
  logic [31:0] remaining;
  logic [47:0] year_est;
  logic found;

  assign blocked = img.limited >= img.limit;

  always_comb begin
    next_state = state;
    next_img = img;
    next_unlocked = unlocked;
    next_extra = extra;
    next_warn = warn;
    next_irq_mask = irq_mask;
    next_day_cnt = day_cnt;
    next_day_trips = day_trips;
    next_avg = avg;
    next_log_word = log_word;
    next_log_addr = log_addr;
    next_rdata = 32'h0;
    next_accept = 1'b0;
    next_reject = 1'b0;
    next_nv_wr = '0;
    ev = '0;
    new_pend = '0;
    served = '0;
    found = 1'b0;
    remaining = 32'h0;
    year_est = 48'h0;
    next_irq_status = irq_status;

    case (state)
      tdc_pkg::ST_LOAD: begin
        // counters come back from the store, never from reset constants
        if (nv_ready) begin
          next_img = nv_image;
          next_extra = 1'b1;
          next_state = tdc_pkg::ST_RUN;
        end
        // counts are not known yet, so no trip may start
        if (trip_req) begin
          next_reject = 1'b1;
        end
      end
      tdc_pkg::ST_RUN: begin
        if (trip_req) begin
          if (!blocked || extra) begin
            next_accept = 1'b1;
            if (blocked) begin
              next_extra = 1'b0;
            end
            if (!img.last_dir_valid || trip_dir != img.last_dir) begin
              // same direction again adds nothing
              // counts hold at all ones rather than wrap back to zero
              if (img.lifetime != '1) begin
                next_img.lifetime = img.lifetime + 32'h1;
              end
              if (img.limited != '1) begin
                next_img.limited = img.limited + 32'h1;
              end
              next_img.last_dir = trip_dir;
              next_img.last_dir_valid = 1'b1;
              new_pend[0] = 1'b1;
              new_pend[1] = 1'b1;
              new_pend[4] = 1'b1;
              if (day_trips != 16'hffff) begin
                next_day_trips = day_trips + 16'h1;
              end
            end
          end else begin
            next_reject = 1'b1;
            ev[tdc_pkg::IRQ_REJECT] = 1'b1;
          end
        end

        if (wr_en) begin
          if (addr == tdc_pkg::REG_LIMITED) begin
            if (unlocked) begin
              next_img.limited = '0;
              next_img.log_count = img.log_count + 16'h1;
              next_log_word = next_img.lifetime;
              next_log_addr = tdc_pkg::NV_LOG_BASE | {4'h0, img.log_count[3:0]};
              new_pend[1] = 1'b1;
              new_pend[5] = 1'b1;
              new_pend[tdc_pkg::SLOT_LOG] = 1'b1;
            end else begin
              ev[tdc_pkg::IRQ_DENIED] = 1'b1;
            end
          end else if (addr == tdc_pkg::REG_LIMIT) begin
            if (unlocked) begin
              next_img.limit = wdata;
              new_pend[2] = 1'b1;
            end else begin
              ev[tdc_pkg::IRQ_DENIED] = 1'b1;
            end
          end else if (addr == tdc_pkg::REG_KEY) begin
            next_unlocked = wdata == img.password;
            ev[tdc_pkg::IRQ_DENIED] = wdata != img.password;
          end else if (addr == tdc_pkg::REG_PASSWORD) begin
            if (unlocked) begin
              next_img.password = wdata;
              new_pend[3] = 1'b1;
            end else begin
              ev[tdc_pkg::IRQ_DENIED] = 1'b1;
            end
          end else if (addr == tdc_pkg::REG_IRQ_MASK) begin
            next_irq_mask = wdata[tdc_pkg::IRQ_W-1:0];
          end else if (addr == tdc_pkg::REG_LOCK) begin
            next_unlocked = 1'b0;
          end
        end
      end
      default: begin
        next_state = tdc_pkg::ST_LOAD;
      end
    endcase

    // trip rate history: smoothed trips per day in fixed point
    // history is volatile, so warn comes late after a power cycle
    if (day_cnt == DAY_CYCLES - 64'h1) begin
      next_day_cnt = 64'h0;
      next_avg = avg - (avg >> tdc_pkg::EMA_SHIFT)
        + ({12'h0, next_day_trips, 4'h0} >> tdc_pkg::EMA_SHIFT);
      next_day_trips = 16'h0;
    end else begin
      next_day_cnt = day_cnt + 64'h1;
    end

    remaining = (next_img.limit > next_img.limited) ?
      next_img.limit - next_img.limited : 32'h0;
    // fraction bits dropped only after the product to keep precision
    year_est = ({16'h0, next_avg} * {39'h0, tdc_pkg::DAYS_PER_YEAR}) >> tdc_pkg::FRAC_W;
    if (trip_done && state == tdc_pkg::ST_RUN) begin
      next_warn = {16'h0, remaining} <= year_est;
    end
    if (new_pend[tdc_pkg::SLOT_LOG]) begin
      next_warn = 1'b0;
    end
    if (next_warn && !warn) begin
      ev[tdc_pkg::IRQ_WARN] = 1'b1;
    end

    next_blocked = next_img.limited >= next_img.limit;
    if (next_blocked && !blocked && state == tdc_pkg::ST_RUN) begin
      ev[tdc_pkg::IRQ_LIMIT] = 1'b1;
    end
    next_fault = next_state == tdc_pkg::ST_RUN && next_blocked;

    // one nonvolatile word per cycle, lowest slot first
    for (int i = 0; i < tdc_pkg::SLOT_N; i++) begin
      if (pend[i] && !found) begin
        found = 1'b1;
        served[i] = 1'b1;
        next_nv_wr.valid = 1'b1;
        case (i)
          0: begin
            next_nv_wr.addr = tdc_pkg::NV_LIFETIME;
            next_nv_wr.data = img.lifetime;
          end
          1: begin
            next_nv_wr.addr = tdc_pkg::NV_LIMITED;
            next_nv_wr.data = img.limited;
          end
          2: begin
            next_nv_wr.addr = tdc_pkg::NV_LIMIT;
            next_nv_wr.data = img.limit;
          end
          3: begin
            next_nv_wr.addr = tdc_pkg::NV_PASSWORD;
            next_nv_wr.data = img.password;
          end
          4: begin
            next_nv_wr.addr = tdc_pkg::NV_DIR;
            next_nv_wr.data = {30'h0, img.last_dir_valid, img.last_dir};
          end
          5: begin
            next_nv_wr.addr = tdc_pkg::NV_LOG_COUNT;
            next_nv_wr.data = {16'h0, img.log_count};
          end
          default: begin
            next_nv_wr.addr = log_addr;
            next_nv_wr.data = log_word;
          end
        endcase
      end
    end
    // a fresh update re-arms its slot even as the old value goes out
    next_pend = (pend & ~served) | new_pend;

    if (rd_en) begin
      if (addr == tdc_pkg::REG_LIFETIME) begin
        next_rdata = img.lifetime;
      end else if (addr == tdc_pkg::REG_LIMITED) begin
        next_rdata = img.limited;
      end else if (addr == tdc_pkg::REG_LIMIT) begin
        next_rdata = img.limit;
      end else if (addr == tdc_pkg::REG_KEY) begin
        next_rdata = {31'h0, unlocked};
      end else if (addr == tdc_pkg::REG_STATUS) begin
        next_rdata = {26'h0, state == tdc_pkg::ST_RUN, img.last_dir_valid, img.last_dir,
                      extra, warn, blocked};
      end else if (addr == tdc_pkg::REG_IRQ_STATUS) begin
        next_rdata = {28'h0, irq_status};
        next_irq_status = '0;
      end else if (addr == tdc_pkg::REG_IRQ_MASK) begin
        next_rdata = {28'h0, irq_mask};
      end else if (addr == tdc_pkg::REG_TRIPS_LEFT) begin
        next_rdata = remaining;
      end else if (addr == tdc_pkg::REG_LOG_COUNT) begin
        next_rdata = {16'h0, img.log_count};
      end
    end
    // set beats the read clear
    next_irq_status = next_irq_status | ev;
    next_irq = |(next_irq_status & next_irq_mask);

    next_display.warn = next_warn;
    next_display.error = next_fault;
    next_display.trips_left = remaining;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= tdc_pkg::ST_LOAD;
      img <= '0;
      unlocked <= 1'b0;
      extra <= 1'b0;
      warn <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      day_cnt <= 64'h0;
      day_trips <= 16'h0;
      avg <= 32'h0;
      pend <= '0;
      log_word <= 32'h0;
      log_addr <= 8'h0;
    end else begin
      state <= next_state;
      img <= next_img;
      unlocked <= next_unlocked;
      extra <= next_extra;
      warn <= next_warn;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      day_cnt <= next_day_cnt;
      day_trips <= next_day_trips;
      avg <= next_avg;
      pend <= next_pend;
      log_word <= next_log_word;
      log_addr <= next_log_addr;
    end
  end

  // every top port leaves straight from one of these flops
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= 32'h0;
      irq <= 1'b0;
      trip_accept <= 1'b0;
      trip_reject <= 1'b0;
      fault <= 1'b0;
      display <= '0;
      nv_wr <= '0;
    end else begin
      rdata <= next_rdata;
      irq <= next_irq;
      trip_accept <= next_accept;
      trip_reject <= next_reject;
      fault <= next_fault;
      display <= next_display;
      nv_wr <= next_nv_wr;
    end
  end

endmodule

// *** pkg/tdc_pkg.sv ***
// tdc_pkg: constants, register map and carrier types of the trip counter
// assumes one 25 MHz clock and an external nonvolatile store behind nv port
package tdc_pkg;

  localparam int CNT_W = 32;
  localparam int LOG_W = 16;
  localparam int FRAC_W = 4;

  // time base for the trip rate history
  localparam longint unsigned CLK_HZ = 25_000_000;
  localparam longint unsigned DAY_S = 86_400;
  localparam logic [63:0] DAY_CYCLES = 64'(CLK_HZ * DAY_S);
  localparam logic [8:0] DAYS_PER_YEAR = 9'h16d;
  localparam int EMA_SHIFT = 3;

  // register byte addresses
  localparam logic [7:0] REG_LIFETIME = 8'h00;
  localparam logic [7:0] REG_LIMITED = 8'h04;
  localparam logic [7:0] REG_LIMIT = 8'h08;
  localparam logic [7:0] REG_KEY = 8'h0c;
  localparam logic [7:0] REG_PASSWORD = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
  localparam logic [7:0] REG_TRIPS_LEFT = 8'h20;
  localparam logic [7:0] REG_LOG_COUNT = 8'h24;
  localparam logic [7:0] REG_LOCK = 8'h28;

  // interrupt status bits
  localparam int IRQ_WARN = 0;
  localparam int IRQ_LIMIT = 1;
  localparam int IRQ_REJECT = 2;
  localparam int IRQ_DENIED = 3;
  localparam int IRQ_W = 4;

  // nonvolatile word addresses and pending-write slots
  localparam logic [7:0] NV_LIFETIME = 8'h00;
  localparam logic [7:0] NV_LIMITED = 8'h01;
  localparam logic [7:0] NV_LIMIT = 8'h02;
  localparam logic [7:0] NV_PASSWORD = 8'h03;
  localparam logic [7:0] NV_DIR = 8'h04;
  localparam logic [7:0] NV_LOG_COUNT = 8'h05;
  localparam logic [7:0] NV_LOG_BASE = 8'h10;
  localparam int SLOT_N = 7;
  localparam int SLOT_LOG = 6;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } tdc_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] lifetime;
    logic [CNT_W-1:0] limited;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] password;
    logic [LOG_W-1:0] log_count;
    logic last_dir;
    logic last_dir_valid;
  } tdc_nv_image_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
  } tdc_nv_wr_t;

  typedef struct packed {
    logic warn;
    logic error;
    logic [CNT_W-1:0] trips_left;
  } tdc_display_t;

endpackage

// *** sim/tdc_nv_model.sv ***
// tdc_nv_model: nonvolatile word store behind the trip counter's nv port
// assumes the counter's clock; contents outlive every counter reset
`timescale 1ns/10ps
module tdc_nv_model #(
  parameter logic [31:0] LIFETIME0 = 32'h5,
  parameter logic [31:0] LIMIT0 = 32'h3,
  parameter logic [31:0] PASSWORD0 = 32'h1234abcd
) (
  input wire logic clock,
  input wire logic reset,
  output logic nv_ready,
  output tdc_pkg::tdc_nv_image_t nv_image,
  input wire tdc_pkg::tdc_nv_wr_t nv_wr
);
  logic [31:0] mem [0:31];
  logic [2:0] wake;
  tdc_pkg::tdc_nv_image_t img;
  // image preset as if copied over from a retired unit
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    mem[tdc_pkg::NV_LIFETIME] = LIFETIME0;
    mem[tdc_pkg::NV_LIMIT] = LIMIT0;
    mem[tdc_pkg::NV_PASSWORD] = PASSWORD0;
    wake = 3'h0;
  end
  always @(posedge clock) begin
    if (nv_wr.valid) begin
      mem[nv_wr.addr[4:0]] <= nv_wr.data;
    end
    wake <= reset ? 3'h0 : (wake == 3'h4 ? wake : wake + 3'h1);
  end
  assign nv_ready = (wake == 3'h4);
  assign img = '{lifetime: mem[0], limited: mem[1], limit: mem[2], password: mem[3],
    log_count: mem[5][15:0], last_dir: mem[4][0], last_dir_valid: mem[4][1]};
  // not ready: show inverted image so a premature load is visible
  assign nv_image = nv_ready ? img : ~img;
endmodule

// *** sim/tdc_trip_counter_assertions.sv ***
// tdc_trip_counter_assertions: port-level checks of the trip counter
// assumes a single clock domain with synchronous active-high reset
`timescale 1ns/10ps
module tdc_trip_counter_assertions #(
  parameter logic [63:0] DAY_CYCLES = tdc_pkg::DAY_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic trip_req,
  input wire logic trip_accept,
  input wire logic trip_reject,
  input wire logic fault,
  input wire tdc_pkg::tdc_display_t display,
  input wire tdc_pkg::tdc_nv_wr_t nv_wr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic fault_q;
  logic extra_used;
  // fault_q lines fault up with the cycle in which the trip was requested
  always_ff @(posedge clock) begin
    fault_q <= reset ? 1'b0 : fault;
    extra_used <= reset ? 1'b0 : (extra_used | (trip_accept & fault_q));
  end
  a_answer_once: assert property (trip_req |=> trip_accept ^ trip_reject)
    else $error("trip request not answered exactly once");
  a_no_stray: assert property (!trip_req |=> !trip_accept && !trip_reject)
    else $error("trip answer without request");
  a_error_fault: assert property (display.error == fault)
    else $error("error display differs from fault");
  a_extra_once: assert property (trip_accept && fault_q |-> !extra_used)
    else $error("second trip accepted while blocked");
  a_rdata_idle: assert property (!rd_en |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_mask_quiet: assert property (wr_en && addr == tdc_pkg::REG_IRQ_MASK && wdata == 32'h0
    |-> ##2 !irq) else $error("irq high with all masked");
  a_dir_saved: assert property (nv_wr.valid && nv_wr.addr == tdc_pkg::NV_DIR |-> nv_wr.data[1])
    else $error("direction stored without valid bit");
  a_reset_quiet: assert property ($fell(reset) |-> !trip_accept && !fault && !irq)
    else $error("outputs active right after reset");
  a_lock_key: assert property (wr_en && addr == tdc_pkg::REG_LOCK ##2 rd_en && addr == tdc_pkg::REG_KEY |=> rdata == 32'h0)
    else $error("still unlocked after lock");
  c_fault_hit: cover property ($rose(fault));
  c_extra_trip: cover property (trip_accept && fault_q);
  c_blocked: cover property (trip_reject && fault);
endmodule
bind tdc_trip_counter tdc_trip_counter_assertions #(.DAY_CYCLES(DAY_CYCLES)) chk (
  .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .irq(irq), .trip_req(trip_req), .trip_accept(trip_accept),
  .trip_reject(trip_reject), .fault(fault), .display(display), .nv_wr(nv_wr));

// *** sim/tdc_trip_counter_bench.sv ***
// tdc_trip_counter_bench: register and trip sequences against the counter
// assumes tdc_nv_model as store, short day for the rate history
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tdc_trip_counter_bench;
  localparam logic [31:0] PW = 32'h1234abcd;
  localparam logic [31:0] NPW = 32'h0bad5eed;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic trip_req = 1'b0;
  logic trip_dir = 1'b0;
  logic trip_done = 1'b0;
  logic [31:0] rdata;
  logic irq, trip_accept, trip_reject, fault, nv_ready;
  tdc_pkg::tdc_display_t display;
  tdc_pkg::tdc_nv_image_t nv_image;
  tdc_pkg::tdc_nv_wr_t nv_wr;
  int err_total = 0;
  int num_checks = 0;
  always #20 clock = ~clock;
  tdc_trip_counter #(.DAY_CYCLES(64'h64)) dut (.clock(clock), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .trip_req(trip_req), .trip_dir(trip_dir), .trip_done(trip_done),
    .trip_accept(trip_accept), .trip_reject(trip_reject), .fault(fault), .display(display),
    .nv_ready(nv_ready), .nv_image(nv_image), .nv_wr(nv_wr));
  tdc_nv_model #(.PASSWORD0(PW)) nv (.clock(clock), .reset(reset), .nv_ready(nv_ready),
    .nv_image(nv_image), .nv_wr(nv_wr));
  task automatic summarize();
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // six idle cycles let the nv words drain before anything else
  task automatic trip(input logic d, input logic acc);
    @(posedge clock);
    trip_req <= 1'b1;
    trip_dir <= d;
    @(posedge clock);
    trip_req <= 1'b0;
    #1;
    `CHK(trip_accept, acc)
    `CHK(trip_reject, ~acc)
    repeat (6) @(posedge clock);
  endtask
  task automatic restart();
    @(posedge clock);
    reset <= 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    summarize();
  end
  initial begin
    restart();
    rd(tdc_pkg::REG_LIFETIME, 32'h5);
    trip(1'b1, 1'b1);
    trip(1'b1, 1'b1);
    trip(1'b0, 1'b1);
    trip(1'b1, 1'b1);
    rd(tdc_pkg::REG_LIFETIME, 32'h8);
    rd(tdc_pkg::REG_LIMITED, 32'h3);
    `CHK(fault, 1'b1)
    `CHK(display.error, 1'b1)
    wr(tdc_pkg::REG_IRQ_MASK, 32'h4);
    trip(1'b0, 1'b1);
    trip(1'b1, 1'b0);
    `CHK(irq, 1'b1)
    @(posedge clock);
    trip_done <= 1'b1;
    @(posedge clock);
    trip_done <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    `CHK(display.warn, 1'b1)
    rd(tdc_pkg::REG_IRQ_STATUS, 32'h7);
    wr(tdc_pkg::REG_LIMIT, 32'ha);
    rd(tdc_pkg::REG_LIMIT, 32'h3);
    rd(tdc_pkg::REG_IRQ_STATUS, 32'h8);
    wr(tdc_pkg::REG_IRQ_MASK, 32'h0);
    rd(8'hfc, 32'h0);
    restart();
    rd(tdc_pkg::REG_LIFETIME, 32'h9);
    `CHK(fault, 1'b1)
    trip(1'b0, 1'b1);
    trip(1'b1, 1'b0);
    rd(tdc_pkg::REG_LIFETIME, 32'h9);
    wr(tdc_pkg::REG_KEY, PW);
    rd(tdc_pkg::REG_KEY, 32'h1);
    wr(tdc_pkg::REG_LIMITED, 32'h0);
    rd(tdc_pkg::REG_LIMITED, 32'h0);
    rd(tdc_pkg::REG_LOG_COUNT, 32'h1);
    `CHK(fault, 1'b0)
    trip(1'b1, 1'b1);
    `CHK(display.trips_left, 32'h2)
    rd(tdc_pkg::REG_TRIPS_LEFT, 32'h2);
    rd(tdc_pkg::REG_STATUS, 32'h38);
    `CHK(nv.mem[tdc_pkg::NV_LOG_COUNT], 32'h1)
    wr(tdc_pkg::REG_LIMIT, 32'h5);
    rd(tdc_pkg::REG_LIMIT, 32'h5);
    wr(tdc_pkg::REG_PASSWORD, NPW);
    wr(tdc_pkg::REG_LOCK, 32'h0);
    rd(tdc_pkg::REG_KEY, 32'h0);
    wr(tdc_pkg::REG_KEY, PW);
    rd(tdc_pkg::REG_KEY, 32'h0);
    wr(tdc_pkg::REG_KEY, NPW);
    rd(tdc_pkg::REG_KEY, 32'h1);
    summarize();
  end
endmodule
